// [core/codec_serial_command_decoder_regs.svh]
// Offsets, field positions, reset values and counts for the serial
// command decoder of the analog codec. Assumes a 16-bit serial word.
// Functional notes
// - Primary word: 14-bit sample, 2-bit mode
// - Each primary word feeds DAC, applies mode
// - Modes 00 and 11 reload plain divisors
// - Mode 01 adds both trims to coarse
// - Mode 10 subtracts tx trim, adds rx
// - Trim alters one period, divisors unchanged
// - Word after mode 11 is secondary
// - Secondary low bits select target register
// - Divisor fields are unsigned
// - Trim fields are two's complement
// - Control D7..D6 select input gain
// - D5 sync, D4 aux, D3 loop, D2 filter
// - Counters reload on reaching zero
// - Tx counters time DAC, rx time ADC
`ifndef CODEC_SERIAL_COMMAND_DECODER_REGS_SVH
`define CODEC_SERIAL_COMMAND_DECODER_REGS_SVH
`define WORD_W          16
`define FIELD_W         6
`define TX_FIELD_LSB    9
`define RX_FIELD_LSB    2
`define SAMPLE_LSB      2
`define SEL_COARSE      2'h0
`define SEL_TRIM        2'h1
`define SEL_FINE        2'h2
`define SEL_CONTROL     2'h3
`define MODE_PLAIN      2'h0
`define MODE_ADVANCE    2'h1
`define MODE_RETARD     2'h2
`define MODE_SECONDARY  2'h3
`define RST_COARSE      6'h12
`define RST_FINE        6'h12
`define RST_TRIM        6'h00
`define RST_CONTROL     6'h00
`define GAIN_LSB        6
`define SYNC_BIT        5
`define AUX_BIT         4
`define LOOP_BIT        3
`define FILTER_BIT      2
`endif

// [core/codec_serial_command_decoder_pkg.sv]
// Types shared by the codec serial command decoder.
// Assumes the constants header is included beside it.
package codec_serial_command_decoder_pkg;
    typedef enum logic [1:0] {
        GAIN_X1,
        GAIN_X2,
        GAIN_X4
    } gain_type;

    typedef struct packed {
        gain_type   gain;
        logic       sync_timing;
        logic       aux_enable;
        logic       loopback;
        logic       bandpass;
    } control_type;

    typedef enum {
        WAIT_PRIMARY,
        WAIT_SECONDARY
    } word_state_type;
endpackage

// [core/codec_serial_command_decoder.sv]
// Command decoder and sample-rate counters of the analog codec.
// Assumes word_valid pulses once per received 16-bit serial word.
`include "codec_serial_command_decoder_regs.svh"

module codec_serial_command_decoder #(
    parameter int FIELD_W = `FIELD_W
) (
    input  wire logic                                      clk,
    input  wire logic                                      sys_rst,
    input  wire logic                                      word_valid,
    input  wire logic [`WORD_W-1:0]                        word_data,
    output logic [13:0]                                    dac_sample,
    output logic                                           dac_strobe,
    output logic                                           adc_strobe,
    output codec_serial_command_decoder_pkg::control_type  control,
    output logic [FIELD_W-1:0]                             tx_coarse_divisor,
    output logic [FIELD_W-1:0]                             rx_coarse_divisor,
    output logic [FIELD_W-1:0]                             tx_fine_divisor,
    output logic [FIELD_W-1:0]                             rx_fine_divisor,
    output logic [FIELD_W-1:0]                             tx_coarse_trim,
    output logic [FIELD_W-1:0]                             rx_coarse_trim
);
    import codec_serial_command_decoder_pkg::*;

    // ------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------
    word_state_type     state_q, state_d;
    logic [13:0]        sample_q, sample_d;
    logic [FIELD_W-1:0] tcd_q, tcd_d, rcd_q, rcd_d;
    logic [FIELD_W-1:0] tfd_q, tfd_d, rfd_q, rfd_d;
    logic [FIELD_W-1:0] ttr_q, ttr_d, rtr_q, rtr_d;
    control_type        ctl_q, ctl_d;
    logic               load_d;
    logic [1:0]         mode_d;
    logic [1:0]         load_mode_q;
    logic               load_q;
    logic [FIELD_W-1:0] tx_field, rx_field;

    assign tx_field = word_data[`TX_FIELD_LSB +: FIELD_W];
    assign rx_field = word_data[`RX_FIELD_LSB +: FIELD_W];

    always_comb begin
        state_d  = state_q;
        sample_d = sample_q;
        tcd_d    = tcd_q;
        rcd_d    = rcd_q;
        tfd_d    = tfd_q;
        rfd_d    = rfd_q;
        ttr_d    = ttr_q;
        rtr_d    = rtr_q;
        ctl_d    = ctl_q;
        load_d   = 1'b0;
        mode_d   = word_data[1:0];
        if (word_valid) begin
            case (state_q)
                WAIT_PRIMARY: begin
                    sample_d = word_data[`WORD_W-1:`SAMPLE_LSB];
                    load_d   = 1'b1;
                    if (word_data[1:0] == `MODE_SECONDARY) begin
                        state_d = WAIT_SECONDARY;
                    end
                end
                WAIT_SECONDARY: begin
                    state_d = WAIT_PRIMARY;
                    case (word_data[1:0])
                        `SEL_COARSE: begin
                            tcd_d = tx_field;
                            rcd_d = rx_field;
                        end
                        `SEL_TRIM: begin
                            ttr_d = tx_field;
                            rtr_d = rx_field;
                        end
                        `SEL_FINE: begin
                            tfd_d = tx_field;
                            rfd_d = rx_field;
                        end
                        default: begin
                            case (word_data[`GAIN_LSB +: 2])
                                2'h1:    ctl_d.gain = GAIN_X2;
                                2'h2:    ctl_d.gain = GAIN_X4;
                                default: ctl_d.gain = GAIN_X1;
                            endcase
                            ctl_d.sync_timing = word_data[`SYNC_BIT];
                            ctl_d.aux_enable  = word_data[`AUX_BIT];
                            ctl_d.loopback    = word_data[`LOOP_BIT];
                            ctl_d.bandpass    = word_data[`FILTER_BIT];
                        end
                    endcase
                end
                default: state_d = WAIT_PRIMARY;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q     <= WAIT_PRIMARY;
            sample_q    <= 14'h0000;
            tcd_q       <= `RST_COARSE;
            rcd_q       <= `RST_COARSE;
            tfd_q       <= `RST_FINE;
            rfd_q       <= `RST_FINE;
            ttr_q       <= `RST_TRIM;
            rtr_q       <= `RST_TRIM;
            ctl_q       <= '{GAIN_X1, 1'b0, 1'b0, 1'b0, 1'b0};
            load_q      <= 1'b0;
            load_mode_q <= 2'h0;
        end else begin
            state_q     <= state_d;
            sample_q    <= sample_d;
            tcd_q       <= tcd_d;
            rcd_q       <= rcd_d;
            tfd_q       <= tfd_d;
            rfd_q       <= rfd_d;
            ttr_q       <= ttr_d;
            rtr_q       <= rtr_d;
            ctl_q       <= ctl_d;
            load_q      <= load_d;
            load_mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // Sample-rate counters, index 0 transmit, 1 receive
    // ------------------------------------------------------------
    // Trims are applied one cycle after the word, so divisors written
    // by a secondary word never meet a trim from the same word.
    logic [FIELD_W-1:0] coarse_div [2];
    logic [FIELD_W-1:0] fine_div [2];
    logic [FIELD_W-1:0] trim [2];
    assign coarse_div[0] = tcd_q;
    assign coarse_div[1] = rcd_q;
    assign fine_div[0]   = tfd_q;
    assign fine_div[1]   = rfd_q;
    assign trim[0]       = ttr_q;
    assign trim[1]       = rtr_q;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic [FIELD_W+1:0] coarse_q, coarse_d;
        logic [FIELD_W-1:0] fine_q, fine_d;
        logic               strobe_d;
        // Strobe flop per channel keeps one driver per variable
        logic               strobe_q;
        logic signed [FIELD_W+1:0] adj;
        always_comb begin
            adj = $signed({2'b00, coarse_div[i]});
            case (load_mode_q)
                `MODE_ADVANCE: adj = adj + $signed({{2{trim[i][FIELD_W-1]}},
                                                    trim[i]});
                `MODE_RETARD: begin
                    if (i == 0) begin
                        adj = adj - $signed({{2{trim[i][FIELD_W-1]}},
                                             trim[i]});
                    end else begin
                        adj = adj + $signed({{2{trim[i][FIELD_W-1]}},
                                             trim[i]});
                    end
                end
                default: adj = $signed({2'b00, coarse_div[i]});
            endcase
            coarse_d = coarse_q;
            fine_d   = fine_q;
            strobe_d = 1'b0;
            if (load_q) begin
                // one period only, stored divisors untouched
                // Trimmed value is not clamped: below zero it wraps to a
                // long period, so the host keeps divisor plus trim in range
                coarse_d = adj;
                fine_d   = fine_div[i];
            end else if (coarse_q == '0) begin
                coarse_d = {2'b00, coarse_div[i]};
                if (fine_q == '0) begin
                    fine_d   = fine_div[i];
                    strobe_d = 1'b1;
                end else begin
                    fine_d = fine_q - 1'b1;
                end
            end else begin
                coarse_d = coarse_q - 1'b1;
            end
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                coarse_q    <= {2'b00, `RST_COARSE};
                fine_q      <= `RST_FINE;
                strobe_q    <= 1'b0;
            end else begin
                coarse_q    <= coarse_d;
                fine_q      <= fine_d;
                strobe_q    <= strobe_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from the flops above
    // ------------------------------------------------------------
    assign dac_sample        = sample_q;
    assign dac_strobe        = g_chan[0].strobe_q;
    assign adc_strobe        = g_chan[1].strobe_q;
    assign control           = ctl_q;
    assign tx_coarse_divisor = tcd_q;
    assign rx_coarse_divisor = rcd_q;
    assign tx_fine_divisor   = tfd_q;
    assign rx_fine_divisor   = rfd_q;
    assign tx_coarse_trim    = ttr_q;
    assign rx_coarse_trim    = rtr_q;
endmodule // codec_serial_command_decoder

// [bench/codec_serial_command_decoder_props.sv]
// Checker on the ports of the codec serial command decoder.
// Assumes one clock domain and the bind at the foot of this file.
module codec_serial_command_decoder_props #(
    parameter int FIELD_W = 6
) (
    input wire logic                                     clk,
    input wire logic                                     sys_rst,
    input wire logic                                     word_valid,
    input wire logic [15:0]                              word_data,
    input wire logic [13:0]                              dac_sample,
    input wire logic                                     dac_strobe,
    input wire logic                                     adc_strobe,
    input wire codec_serial_command_decoder_pkg::control_type control,
    input wire logic [FIELD_W-1:0]                       tx_coarse_divisor,
    input wire logic [FIELD_W-1:0]                       rx_coarse_divisor,
    input wire logic [FIELD_W-1:0]                       tx_fine_divisor,
    input wire logic [FIELD_W-1:0]                       rx_fine_divisor,
    input wire logic [FIELD_W-1:0]                       tx_coarse_trim,
    input wire logic [FIELD_W-1:0]                       rx_coarse_trim
);
    timeunit 1ns;
    timeprecision 1ns;
    import codec_serial_command_decoder_pkg::*;
    logic sec_q;
    logic sec_d;
    logic [1:0] sel;
    assign sel = word_data[1:0];
    always_comb begin
        sec_d = sec_q;
        if (word_valid) begin
            sec_d = !sec_q && sel == 2'h3;
        end
    end
    always_ff @(posedge clk) begin
        sec_q <= sys_rst ? 1'b0 : sec_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_dac_load: assert property (word_valid && !sec_q |=>
        dac_sample == $past(word_data[15:2])) else $error("dac load");
    a_dac_kept: assert property (word_valid && sec_q |=>
        $stable(dac_sample)) else $error("dac changed");
    a_coarse_sec: assert property (
        word_valid && sec_q && sel == 2'h0 |=>
        tx_coarse_divisor == $past(word_data[14:9]) &&
        rx_coarse_divisor == $past(word_data[7:2])) else $error("coarse");
    a_trim_sec: assert property (
        word_valid && sec_q && sel == 2'h1 |=>
        tx_coarse_trim == $past(word_data[14:9]) &&
        rx_coarse_trim == $past(word_data[7:2])) else $error("trim");
    a_fine_sec: assert property (
        word_valid && sec_q && sel == 2'h2 |=>
        tx_fine_divisor == $past(word_data[14:9]) &&
        rx_fine_divisor == $past(word_data[7:2])) else $error("fine");
    a_gain_map: assert property (
        word_valid && sec_q && sel == 2'h3 |=>
        control.gain == ($past(word_data[7:6]) == 2'h3 ? 2'h0 :
        $past(word_data[7:6]))) else $error("gain");
    a_ctrl_bits: assert property (
        word_valid && sec_q && sel == 2'h3 |=>
        control[3:0] == $past(word_data[5:2])) else $error("ctrl");
    a_primary_keeps: assert property (word_valid && !sec_q |=>
        $stable(tx_coarse_divisor) && $stable(rx_coarse_divisor))
        else $error("divisor changed");
endmodule // codec_serial_command_decoder_props

bind codec_serial_command_decoder codec_serial_command_decoder_props #(
    .FIELD_W(FIELD_W)) codec_serial_command_decoder_props_inst (
    .clk(clk), .sys_rst(sys_rst), .word_valid(word_valid),
    .word_data(word_data), .dac_sample(dac_sample), .control(control),
    .dac_strobe(dac_strobe), .adc_strobe(adc_strobe),
    .tx_coarse_divisor(tx_coarse_divisor),
    .rx_coarse_divisor(rx_coarse_divisor),
    .tx_fine_divisor(tx_fine_divisor), .rx_fine_divisor(rx_fine_divisor),
    .tx_coarse_trim(tx_coarse_trim), .rx_coarse_trim(rx_coarse_trim));

// [bench/host_port_model.sv]
// Host serial port model: hands over one 16-bit word per transfer.
// Assumes the bench calls send_word from one process only.
module host_port_model #(
    parameter int GAP = 3
) (
    input wire logic clk,
    output logic     word_valid,
    output logic [15:0] word_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        word_valid = 1'b0;
        word_data  = 16'hA5C3;
    end
    task automatic send_word(input logic [15:0] w);
        @(posedge clk);
        word_valid <= 1'b1;
        word_data  <= w;
        @(posedge clk);
        word_valid <= 1'b0;
        // Inverted idle data so a stale word never passes as fresh
        word_data  <= ~w;
        repeat (GAP) @(posedge clk);
    endtask
endmodule // host_port_model

// [bench/codec_serial_command_decoder_bench.sv]
// Self-checking bench for the codec serial command decoder.
// Assumes the host model drives words and the checker is bound.
module codec_serial_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import codec_serial_command_decoder_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic word_valid;
    logic [15:0] word_data;
    logic [13:0] dac_sample;
    logic dac_strobe;
    logic adc_strobe;
    control_type control;
    logic [5:0] tcd, rcd, tfd, rfd, tct, rct;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    codec_serial_command_decoder codec_serial_command_decoder_inst (
        .clk(clk), .sys_rst(sys_rst), .word_valid(word_valid),
        .word_data(word_data), .dac_sample(dac_sample), .control(control),
        .dac_strobe(dac_strobe), .adc_strobe(adc_strobe),
        .tx_coarse_divisor(tcd), .rx_coarse_divisor(rcd),
        .tx_fine_divisor(tfd), .rx_fine_divisor(rfd),
        .tx_coarse_trim(tct), .rx_coarse_trim(rct));
    host_port_model host_port_model_inst (.clk(clk),
        .word_valid(word_valid), .word_data(word_data));
    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hangs end as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    function automatic logic [15:0] mk(logic [5:0] t, r, logic [1:0] s);
        return {1'b0, t, 1'b0, r, s};
    endfunction
    task automatic prog(logic [15:0] sec);
        host_port_model_inst.send_word({14'h0ACE, 2'h3});
        host_port_model_inst.send_word(sec);
        check("dac kept", 16'(dac_sample), 16'h0ACE);
        host_port_model_inst.send_word(16'h0000);
    endtask
    task automatic t_primary();
        // Mode 00 so the next word is taken as a primary again
        host_port_model_inst.send_word(16'h1230);
        check("dac sample", 16'(dac_sample), 16'h048C);
        $display("test primary done");
    endtask
    task automatic t_registers();
        logic [3:0] b;
        prog(mk(6'h03, 6'h02, 2'h2));
        check("tx fine", 16'(tfd), 16'h0003);
        check("rx fine", 16'(rfd), 16'h0002);
        prog(mk(6'h02, 6'h3F, 2'h1));
        check("tx trim", 16'(tct), 16'h0002);
        check("rx trim", 16'(rct), 16'h003F);
        for (int g = 0; g < 4; g++) begin
            b = 4'hA ^ 4'(g);
            prog({8'h00, 2'(g), b, 2'h3});
            check("control", 16'(control),
                16'({(g == 3) ? 2'h0 : 2'(g), b}));
        end
        // Coarse divisors last since they set the rate
        prog(mk(6'h04, 6'h05, 2'h0));
        check("tx coarse", 16'(tcd), 16'h0004);
        check("rx coarse", 16'(rcd), 16'h0005);
        $display("test registers done");
    endtask
    task automatic t_timing();
        int tt[3], tr[3], pt[3], pr[3];
        for (int m = 0; m < 3; m++) begin
            host_port_model_inst.send_word({14'h0155, 2'(m)});
            tt[m] = 0;
            tr[m] = 0;
            pt[m] = 0;
            pr[m] = 0;
            for (int n = 1; n < 100; n++) begin
                @(posedge clk);
                #1;
                if (dac_strobe === 1'b1 && tt[m] == 0) tt[m] = n;
                else if (dac_strobe === 1'b1 && pt[m] == 0) pt[m] = n - tt[m];
                if (adc_strobe === 1'b1 && tr[m] == 0) tr[m] = n;
                else if (adc_strobe === 1'b1 && pr[m] == 0) pr[m] = n - tr[m];
            end
            check("tx period", 16'(pt[m]), 16'h0014);
            check("rx period", 16'(pr[m]), 16'h0012);
        end
        check("tx advance", 16'(tt[1] - tt[0]), 16'h0002);
        check("rx advance", 16'(tr[0] - tr[1]), 16'h0001);
        check("tx retard", 16'(tt[0] - tt[2]), 16'h0002);
        check("rx retard", 16'(tr[0] - tr[2]), 16'h0001);
        $display("test timing done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_primary();
        t_registers();
        t_timing();
        give_verdict();
    end
endmodule // codec_serial_command_decoder_bench
